// file: verilog/acr_pkg.sv
// constants for the converter configuration port: map, fields, resets, frame layout
// assumes a single 25 MHz system clock domain samples the serial pins
package acr_pkg;
    localparam logic [7:0] ADDR_PORT_CFG   = 8'h00;
    localparam logic [7:0] ADDR_PART_ID    = 8'h01;
    localparam logic [7:0] ADDR_GRADE      = 8'h02;
    localparam logic [7:0] ADDR_CHAN_SEL   = 8'h05;
    localparam logic [7:0] ADDR_XFER       = 8'hff;
    localparam logic [7:0] ADDR_PROG_FIRST = 8'h08;
    localparam logic [7:0] ADDR_PROG_LAST  = 8'h25;

    localparam logic [7:0] PORT_CFG_RESET  = 8'h18;
    localparam logic [7:0] PORT_CFG_FIXED  = 8'h18;
    localparam logic [7:0] CHAN_SEL_RESET  = 8'h0f;
    localparam logic [7:0] CHAN_SEL_MASK   = 8'h3f;
    localparam logic [2:0] GRADE_FAST      = 3'h0;
    localparam logic [2:0] GRADE_SLOW      = 3'h1;

    localparam int PCFG_LSB_HI  = 6;
    localparam int PCFG_SRST_HI = 5;
    localparam int PCFG_SRST_LO = 2;
    localparam int PCFG_LSB_LO  = 1;
    localparam int GRADE_POS    = 4;
    localparam int XFER_BIT     = 0;

    localparam int INSTR_BITS   = 16;
    localparam int RW_BIT       = 15;
    localparam int WL_HI_BIT    = 14;
    localparam int WL_LO_BIT    = 13;
    localparam logic [4:0] INSTR_LAST = 5'h0f;
    localparam logic [2:0] BYTE_LAST  = 3'h7;
    localparam logic [1:0] WL_STREAM  = 2'h3;
    localparam int NUM_TARGETS  = 6;

    typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} acr_state_t;
endpackage

// file: verilog/acr_sync.sv
// two-flop synchroniser for one pin sampled on the system clock
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps
module acr_sync
    import acr_pkg::*;
(
    // clock and control
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic rst_val,
    // pin in, synchronised level out
    input  wire logic pin,
    output logic      level
);
    logic meta_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            // park at the pin's idle level so no false edge follows reset
            meta_q <= rst_val;
            level  <= rst_val;
        end
        else if (clk_en)
        begin
            meta_q <= pin;
            level  <= meta_q;
        end
    end
endmodule // acr_sync

// file: verilog/acr_regs.sv
// configuration register bank behind a three-wire serial port
// assumes the shift clock is far slower than clock (here 320 ns vs 40 ns) and
// that select and shift clock arrive asynchronously on pins
`timescale 1ns/1ps
module acr_regs
    import acr_pkg::*;
#(
    parameter logic [7:0] PART_ID    = 8'h5a, // arbitrary value
    parameter logic [2:0] GRADE_CODE = GRADE_FAST
)
(
    // system
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    // serial pins
    input  wire logic                   select_n_line,
    input  wire logic                   sclk,
    input  wire logic                   sdio_i,
    output logic                        sdio_o,
    output logic                        sdio_oe,
    // converter side
    output logic [NUM_TARGETS-1:0]      target_sel_q,
    output logic                        lsb_first_q,
    output logic                        soft_reset_q,
    output logic                        xfer_pulse_q,
    output logic [7:0]                  prog_wr_addr_q,
    output logic [7:0]                  prog_wr_data_q,
    output logic [NUM_TARGETS-1:0]      prog_wr_en_q
);
    logic sel_n_s, sclk_s, sdio_s;

    acr_sync u_sync_sel  (.clock(clock), .rst(rst), .clk_en(clk_en), .rst_val(1'b1),
                          .pin(select_n_line), .level(sel_n_s));
    acr_sync u_sync_sclk (.clock(clock), .rst(rst), .clk_en(clk_en), .rst_val(1'b0),
                          .pin(sclk), .level(sclk_s));
    acr_sync u_sync_sdio (.clock(clock), .rst(rst), .clk_en(clk_en), .rst_val(1'b0),
                          .pin(sdio_i), .level(sdio_s));

    // edge detection on synchronised levels
    logic sclk_prev_q, sel_prev_q;
    wire  sclk_rise = sclk_s & ~sclk_prev_q;
    wire  sclk_fall = ~sclk_s & sclk_prev_q;
    wire  sel_low   = ~sel_n_s;
    wire  sel_rise  = sel_n_s & ~sel_prev_q;

    acr_state_t  state_q;
    logic [4:0]  bit_cnt_q;
    logic [2:0]  byte_bit_q;
    logic [15:0] instr_q;
    logic [7:0]  shift_q;
    logic [7:0]  addr_q;
    logic [1:0]  bytes_left_q;
    logic [7:0]  port_cfg_q;
    logic [7:0]  chan_sel_q;
    logic [7:0]  tx_q;

    // program region: staged bytes written from the port, one per address
    logic [7:0] stage_mem [ADDR_PROG_FIRST:ADDR_PROG_LAST];

    function automatic logic [7:0] bitrev(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
            r[i] = v[7-i];
        return r;
    endfunction

    function automatic logic in_prog(input logic [7:0] a);
        return (a >= ADDR_PROG_FIRST) && (a <= ADDR_PROG_LAST);
    endfunction

    // rx byte in wire order; lsb-first mode reverses it before use
    wire [7:0] rx_byte  = {shift_q[6:0], sdio_s};
    wire [7:0] wr_byte  = lsb_first_q ? bitrev(rx_byte) : rx_byte;
    wire       is_write = ~instr_q[RW_BIT];
    wire [1:0] word_len = {instr_q[WL_HI_BIT], instr_q[WL_LO_BIT]};
    wire       stream   = (word_len == WL_STREAM);
    wire       instr_done = (state_q == ST_INSTR) && sclk_rise && (bit_cnt_q == INSTR_LAST);
    wire       byte_done  = (state_q == ST_DATA) && sclk_rise && (byte_bit_q == BYTE_LAST);
    wire [15:0] instr_nxt = {instr_q[14:0], sdio_s};
    wire [15:0] instr_fix = lsb_first_q ? {bitrev(instr_nxt[7:0]), bitrev(instr_nxt[15:8])} : instr_nxt;

    // read data mux; undefined bits read zero
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (addr_q)
            ADDR_PORT_CFG: rd_byte = port_cfg_q;
            ADDR_PART_ID:  rd_byte = PART_ID;
            ADDR_GRADE:    rd_byte = {1'b0, GRADE_CODE, 4'h0};
            ADDR_CHAN_SEL: rd_byte = chan_sel_q;
            default:       rd_byte = in_prog(addr_q) ? stage_mem[addr_q] : 8'h00;
        endcase
    end
    wire [7:0] rd_wire = lsb_first_q ? bitrev(rd_byte) : rd_byte;

    // port config write: either nibble copy sets the control
    wire pc_lsb  = wr_byte[PCFG_LSB_HI]  | wr_byte[PCFG_LSB_LO];
    wire pc_srst = wr_byte[PCFG_SRST_HI] | wr_byte[PCFG_SRST_LO];
    wire [7:0] pc_new = PORT_CFG_FIXED | ({7'h00, pc_lsb} << PCFG_LSB_HI) | ({7'h00, pc_lsb} << PCFG_LSB_LO)
                        | ({7'h00, pc_srst} << PCFG_SRST_HI) | ({7'h00, pc_srst} << PCFG_SRST_LO);
    wire do_write = byte_done && is_write;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sclk_prev_q  <= 1'b0;
            sel_prev_q   <= 1'b1;
            state_q      <= ST_IDLE;
            bit_cnt_q    <= 5'h00;
            byte_bit_q   <= 3'h0;
            instr_q      <= 16'h0000;
            shift_q      <= 8'h00;
            addr_q       <= 8'h00;
            bytes_left_q <= 2'h0;
            tx_q         <= 8'h00;
        end
        else if (clk_en)
        begin
            sclk_prev_q <= sclk_s;
            sel_prev_q  <= sel_n_s;
            if (sel_rise && (state_q == ST_DATA) && stream)
                state_q <= ST_IDLE;
            else if (sel_rise && ((state_q == ST_INSTR) || (byte_bit_q != 3'h0)))
            begin
                state_q    <= ST_IDLE;
                byte_bit_q <= 3'h0;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                        bit_cnt_q <= 5'h00;
                        if (sel_low)
                            state_q <= ST_INSTR;
                    end
                    ST_INSTR:
                        if (sclk_rise)
                        begin
                            bit_cnt_q <= bit_cnt_q + 5'h01;
                            instr_q   <= instr_done ? instr_fix : instr_nxt;
                            if (instr_done)
                            begin
                                state_q      <= ST_DATA;
                                addr_q       <= instr_fix[7:0];
                                bytes_left_q <= {instr_fix[WL_HI_BIT], instr_fix[WL_LO_BIT]};
                                byte_bit_q   <= 3'h0;
                            end
                        end
                    ST_DATA:
                        if (sclk_rise)
                        begin
                            byte_bit_q <= byte_bit_q + 3'h1;
                            shift_q    <= rx_byte;
                            if (byte_done)
                            begin
                                addr_q <= addr_q - 8'h01;
                                if (!stream)
                                begin
                                    bytes_left_q <= bytes_left_q - 2'h1;
                                    if (bytes_left_q == 2'h0)
                                        state_q <= ST_IDLE;
                                end
                            end
                        end
                    default: state_q <= ST_IDLE;
                endcase
            end
            // read data shifts out on falling edges
            if ((state_q == ST_DATA) && !is_write && sclk_fall)
                tx_q <= (byte_bit_q == 3'h0) ? rd_wire : {tx_q[6:0], 1'b0};
            else if ((state_q == ST_INSTR) && instr_done)
                tx_q <= 8'h00;
        end
    end

    // register file writes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            port_cfg_q     <= PORT_CFG_RESET;
            chan_sel_q     <= CHAN_SEL_RESET;
            xfer_pulse_q   <= 1'b0;
            prog_wr_en_q   <= '0;
            prog_wr_addr_q <= 8'h00;
            prog_wr_data_q <= 8'h00;
        end
        else if (clk_en)
        begin
            xfer_pulse_q <= 1'b0;
            prog_wr_en_q <= '0;
            if (do_write)
            begin
                unique case (addr_q)
                    ADDR_PORT_CFG: port_cfg_q <= pc_new;
                    ADDR_CHAN_SEL: chan_sel_q <= wr_byte & CHAN_SEL_MASK;
                    ADDR_XFER:     xfer_pulse_q <= wr_byte[XFER_BIT];
                    default:
                        if (in_prog(addr_q))
                        begin
                            prog_wr_addr_q <= addr_q;
                            prog_wr_data_q <= wr_byte;
                            prog_wr_en_q   <= chan_sel_q[NUM_TARGETS-1:0];
                        end
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (clk_en && do_write && in_prog(addr_q))
            stage_mem[addr_q] <= wr_byte;
    end

    // outputs registered
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sdio_o       <= 1'b0;
            sdio_oe      <= 1'b0;
            target_sel_q <= CHAN_SEL_RESET[NUM_TARGETS-1:0];
            lsb_first_q  <= 1'b0;
            soft_reset_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sdio_o       <= tx_q[7];
            sdio_oe      <= (state_q == ST_DATA) && !is_write && sel_low;
            target_sel_q <= chan_sel_q[NUM_TARGETS-1:0];
            lsb_first_q  <= port_cfg_q[PCFG_LSB_HI];
            soft_reset_q <= port_cfg_q[PCFG_SRST_HI];
        end
    end

    // assertions
    property p_port_reset;
        @(posedge clock) $fell(rst) |-> port_cfg_q == PORT_CFG_RESET;
    endproperty
    a_port_reset: assert property (p_port_reset) else $error("port config reset wrong");

    property p_chan_reset;
        @(posedge clock) $fell(rst) |-> chan_sel_q == CHAN_SEL_RESET;
    endproperty
    a_chan_reset: assert property (p_chan_reset) else $error("channel select reset wrong");

    property p_fixed_bits;
        @(posedge clock) disable iff (rst) (port_cfg_q & PORT_CFG_FIXED) == PORT_CFG_FIXED && !port_cfg_q[7] && !port_cfg_q[0];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("port config fixed bits");

    property p_mirror;
        @(posedge clock) disable iff (rst) port_cfg_q[PCFG_LSB_HI] == port_cfg_q[PCFG_LSB_LO];
    endproperty
    a_mirror: assert property (p_mirror) else $error("nibbles not mirrored");

    property p_chan_undef;
        @(posedge clock) disable iff (rst) chan_sel_q[7:6] == 2'h0;
    endproperty
    a_chan_undef: assert property (p_chan_undef) else $error("undefined select bits set");

    property p_sel_en;
        @(posedge clock) disable iff (rst) clk_en && do_write && in_prog(addr_q) |=> (prog_wr_en_q == $past(chan_sel_q[5:0]));
    endproperty
    a_sel_en: assert property (p_sel_en) else $error("target enables wrong");

    property p_abort;
        @(posedge clock) disable iff (rst) clk_en && sel_rise && state_q == ST_INSTR |=> state_q == ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("select rise did not abort");

    property p_xfer;
        @(posedge clock) disable iff (rst) xfer_pulse_q |=> !xfer_pulse_q || $past(do_write);
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer pulse stuck");

    sequence s_idle_two;
        state_q == ST_IDLE ##1 state_q == ST_IDLE;
    endsequence

    property p_oe_idle;
        @(posedge clock) disable iff (rst) s_idle_two |-> !sdio_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("driving while idle");
endmodule // acr_regs

// file: testbench/acr_host.sv
// serial host model: drives select, shift clock and the shared data pin
// assumes one system clock; shift clock idles low and stands still between frames
`timescale 1ns/1ps
module acr_host
    import acr_pkg::*;
(
    // system
    input  wire logic clock,
    input  wire logic lsb,
    // serial pins
    output logic      select_n_line,
    output logic      sclk,
    output logic      sdio_i,
    input  wire logic sdio_o,
    input  wire logic sdio_oe
);
    logic h_d = 1'b0;
    logic h_oe = 1'b0;
    logic h_float = 1'b0;

    initial select_n_line = 1'b1;
    initial sclk = 1'b0;
    // undriven pin toggles so a stale level never passes for read data
    always @(posedge clock) h_float <= ~h_float;
    assign sdio_i = sdio_oe ? sdio_o : (h_oe ? h_d : h_float);

    // one frame; stop > 0 raises select after that many bits
    task automatic frame(input logic rw, input logic [1:0] wl, input logic [7:0] a, input int nb,
                         input logic [15:0] wd, input int stop, output logic [15:0] rd);
        logic [15:0] ins;
        int          n;
        int          k;
        int          p;
        ins = {rw, wl, 5'h00, a};
        n = (stop > 0) ? stop : 16 + 8 * nb;
        rd = 16'h0000;
        @(posedge clock) select_n_line <= 1'b0;
        repeat (4) @(posedge clock);
        for (k = 0; k < n; k++)
        begin
            p = 8 * (nb - 1 - (k - 16) / 8) + (lsb ? k % 8 : 7 - k % 8);
            h_oe <= !(rw && k >= 16);
            h_d <= (k < 16) ? ins[lsb ? k : 15 - k] : wd[p];
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
            sclk <= 1'b1;
            repeat (2) @(posedge clock);
            if (k >= 16)
                rd[p] = sdio_i;
            repeat (2) @(posedge clock);
        end
        sclk <= 1'b0;
        repeat (4) @(posedge clock);
        select_n_line <= 1'b1;
        h_oe <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
endmodule // acr_host

// file: testbench/acr_regs_tb.sv
// self-checking bench for the configuration register bank
// assumes the host model in acr_host.sv; only defined locations are written
`timescale 1ns/1ps
module acr_regs_tb;
    import acr_pkg::*;
    localparam logic [7:0] PART_ID = 8'h5a; // arbitrary value

    logic                   clock = 1'b0;
    logic                   rst = 1'b1;
    logic                   clk_en = 1'b1;
    logic                   lsb = 1'b0;
    logic                   select_n_line;
    logic                   sclk;
    logic                   sdio_i;
    logic                   sdio_o;
    logic                   sdio_oe;
    logic [NUM_TARGETS-1:0] target_sel_q;
    logic                   lsb_first_q;
    logic                   soft_reset_q;
    logic                   xfer_pulse_q;
    logic [7:0]             prog_wr_addr_q;
    logic [7:0]             prog_wr_data_q;
    logic [NUM_TARGETS-1:0] prog_wr_en_q;
    logic [NUM_TARGETS-1:0] wr_en;
    logic [7:0]             wr_addr;
    logic [7:0]             wr_data;
    logic [15:0]            r;
    int                     wr_count = 0;
    int                     xfer_count = 0;
    int                     bad_count = 0;
    int                     checks = 0;
    int                     n;

    always #20 clock = ~clock;

    acr_regs #(.PART_ID(PART_ID), .GRADE_CODE(GRADE_SLOW)) i_acr_regs (
        .clock(clock), .rst(rst), .clk_en(clk_en), .select_n_line(select_n_line), .sclk(sclk),
        .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .target_sel_q(target_sel_q),
        .lsb_first_q(lsb_first_q), .soft_reset_q(soft_reset_q), .xfer_pulse_q(xfer_pulse_q),
        .prog_wr_addr_q(prog_wr_addr_q), .prog_wr_data_q(prog_wr_data_q), .prog_wr_en_q(prog_wr_en_q));

    acr_host i_acr_host (
        .clock(clock), .lsb(lsb), .select_n_line(select_n_line), .sclk(sclk),
        .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe));

    // enables are one-cycle pulses, so capture them where they stand
    always @(posedge clock)
    begin
        if (|prog_wr_en_q)
        begin
            wr_count <= wr_count + 1;
            wr_en <= prog_wr_en_q;
            wr_addr <= prog_wr_addr_q;
            wr_data <= prog_wr_data_q;
        end
        if (xfer_pulse_q === 1'b1)
            xfer_count <= xfer_count + 1;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_acr_host.frame(1'b0, 2'h0, a, 1, {8'h00, d}, 0, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_acr_host.frame(1'b1, 2'h0, a, 1, 16'h0000, 0, r);
        check("read data", r, {8'h00, exp});
    endtask

    task automatic t_reset;
        check("target_sel_q", 16'(target_sel_q), 16'h000f);
        check("lsb_first_q", 16'(lsb_first_q), 16'h0000);
        rd(ADDR_PORT_CFG, 8'h18);
        rd(ADDR_CHAN_SEL, 8'h0f);
        $display("test reset done");
    endtask

    task automatic t_ident;
        rd(ADDR_PART_ID, PART_ID);
        wr(ADDR_PART_ID, 8'ha5);
        rd(ADDR_PART_ID, PART_ID);
        rd(ADDR_GRADE, {1'b0, GRADE_SLOW, 4'h0});
        $display("test ident done");
    endtask

    task automatic t_select;
        wr(ADDR_CHAN_SEL, 8'hff);
        rd(ADDR_CHAN_SEL, 8'h3f);
        check("target_sel_q", 16'(target_sel_q), 16'h003f);
        wr(ADDR_CHAN_SEL, 8'h12);
        n = wr_count;
        wr(8'h09, 8'h01);
        check("wr count", 16'(wr_count - n), 16'h0001);
        check("wr enables", 16'(wr_en), 16'h0012);
        check("wr addr data", {wr_addr, wr_data}, 16'h0901);
        n = xfer_count;
        wr(ADDR_XFER, 8'h01);
        check("xfer count", 16'(xfer_count - n), 16'h0001);
        wr(ADDR_CHAN_SEL, 8'h0f);
        $display("test select done");
    endtask

    task automatic t_stream;
        n = wr_count;
        i_acr_host.frame(1'b0, WL_STREAM, 8'h09, 2, 16'h1122, 0, r);
        check("stream count", 16'(wr_count - n), 16'h0002);
        check("stream last", {wr_addr, wr_data}, 16'h0822);
        i_acr_host.frame(1'b1, WL_STREAM, 8'h09, 2, 16'h0000, 0, r);
        check("stream read", r, 16'h1122);
        n = wr_count;
        i_acr_host.frame(1'b0, 2'h1, 8'h09, 2, 16'h3344, 0, r);
        check("two byte count", 16'(wr_count - n), 16'h0002);
        check("two byte last", {wr_addr, wr_data}, 16'h0844);
        i_acr_host.frame(1'b1, 2'h1, 8'h09, 2, 16'h0000, 0, r);
        check("two byte read", r, 16'h3344);
        $display("test stream done");
    endtask

    task automatic t_abort;
        i_acr_host.frame(1'b0, 2'h0, ADDR_CHAN_SEL, 1, 16'h0003, 20, r);
        check("target_sel_q", 16'(target_sel_q), 16'h000f);
        rd(ADDR_CHAN_SEL, 8'h0f);
        $display("test abort done");
    endtask

    task automatic t_portcfg;
        wr(ADDR_PORT_CFG, 8'h58);
        check("lsb_first_q", 16'(lsb_first_q), 16'h0001);
        lsb = 1'b1;
        wr(ADDR_PORT_CFG, 8'h18);
        check("lsb_first_q", 16'(lsb_first_q), 16'h0000);
        lsb = 1'b0;
        wr(ADDR_PORT_CFG, 8'h1a);
        check("lsb_first_q", 16'(lsb_first_q), 16'h0001);
        lsb = 1'b1;
        wr(ADDR_PORT_CFG, 8'h5a);
        rd(ADDR_PORT_CFG, 8'h5a);
        wr(ADDR_CHAN_SEL, 8'h21);
        rd(ADDR_CHAN_SEL, 8'h21);
        check("target_sel_q", 16'(target_sel_q), 16'h0021);
        wr(ADDR_CHAN_SEL, 8'h0f);
        wr(ADDR_PORT_CFG, 8'h18);
        lsb = 1'b0;
        wr(ADDR_PORT_CFG, 8'h3c);
        check("soft_reset_q", 16'(soft_reset_q), 16'h0001);
        wr(ADDR_PORT_CFG, 8'h18);
        check("soft_reset_q", 16'(soft_reset_q), 16'h0000);
        $display("test portcfg done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_reset();
        t_ident();
        t_select();
        t_stream();
        t_abort();
        t_portcfg();
        report_and_stop();
    end

    // frames take about 205 cycles each (269 for two-byte frames) and fewer than 40 are sent
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        $display("Error watchdog expected end seen hang");
        report_and_stop();
    end
endmodule // acr_regs_tb
